// ===== rtl/prcm_top.sv
// Top level: per-port reference clock mode select for a multi-port switch
//
// Contract
// RULE1: Global mode port uses the shared global reference clock for receive and transmit.
// RULE2: Local mode port uses its own port reference clock for receive and transmit.
// RULE3: Spread-spectrum port clock in local mode needs a global clock without spread-spectrum.
// RULE4: Mode change accepted anytime; new reference clock must already be stable.
// RULE5: Mode change returns the port PHY to Detect, not a surprise link-down.
// RULE6: Reference clock change re-initialises the port serializer before link bring-up.
// RULE7: After a mode change retrain the link unless the port is disabled.
// RULE8: Global to local needs port clock at the global nominal 100 or 125 MHz.
// RULE9: Global to local only while the global clock has no spread-spectrum.
// RULE10: Local to global only when the strap-selected global frequency is 100 MHz; the code accepts it whatever global_clock_freq_select_i was.
// RULE11: Local mode shared port clock is valid with or without spread-spectrum.
// RULE12: Local mode separate partner clock is valid only without port spread-spectrum.
// RULE13: Each port mode comes from its field in the port clock mode register.
// RULE14: Port modes and slot clock bits start from the boot straps; 7 reserved.
// RULE15: A mode change on one port leaves every other port undisturbed.
`timescale 1ns/100ps
module prcm_top
	import prcm_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// Boot straps, sampled while reset is held
	input wire logic [2:0] boot_clock_mode_straps_i,
	input wire logic global_clock_freq_select_i,
	// Mode change request
	input wire logic mode_wr_i,
	input wire logic [PORT_IDX_W-1:0] mode_wr_port_i,
	input wire logic mode_wr_value_i,
	// Port state from the link layer
	input wire logic [NUM_PORTS-1:0] port_disabled_i,
	input wire logic [NUM_PORTS-1:0] phy_link_down_i,
	// Clock selection and PHY control
	output logic [NUM_PORTS-1:0] port_clock_mode_reg_o,
	output logic [NUM_PORTS-1:0] ref_sel_local_o,
	output logic [NUM_PORTS-1:0] slot_clock_cfg_o,
	output logic [NUM_PORTS-1:0] phy_force_detect_o,
	output logic [NUM_PORTS-1:0] serdes_reinit_o,
	output logic [NUM_PORTS-1:0] link_retrain_o,
	output logic [NUM_PORTS-1:0] surprise_link_down_o,
	output logic [NUM_PORTS-1:0] mode_change_busy_o,
	// Boot vector status
	output logic [2:0] boot_clock_mode_o,
	output logic global_clock_freq_select_o
);

	// ****************************************
	// Boot strap capture
	// ****************************************
	logic [2:0] strap_eff;
	logic strap_local_not0;
	logic strap_local_all;
	logic sclk_p0;
	logic sclk_other;
	logic [NUM_PORTS-1:0] mode_bus;
	logic [NUM_PORTS-1:0] busy_bus;
	logic [NUM_PORTS-1:0] sclk_bus;

	// Reserved strap value falls back to all ports global, slot clock clear
	assign strap_eff = (boot_clock_mode_straps_i == STRAP_RESERVED) ? 3'h0 :
		boot_clock_mode_straps_i; // RULE14
	assign strap_local_all = (strap_eff == STRAP_ALL_LOCAL);
	assign strap_local_not0 = strap_local_all || (strap_eff == STRAP_LOCAL_NOT0_A) ||
		(strap_eff == STRAP_LOCAL_NOT0_B);
	assign sclk_p0 = SCLK_PORT0_TABLE[strap_eff];
	assign sclk_other = SCLK_OTHER_TABLE[strap_eff];

	// Boot vector is only looked at during reset; afterwards it has no effect
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			boot_clock_mode_o <= strap_eff;
			global_clock_freq_select_o <= global_clock_freq_select_i;
		end
	end

	// ****************************************
	// Per-port sequencers
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
			prcm_port_if pif ();
			logic init_local;
			logic sclk_init;

			if (gi == 0) begin : g_p0
				assign init_local = strap_local_all;
				assign sclk_init = sclk_p0;
			end else begin : g_pn
				assign init_local = strap_local_not0 && LOCAL_CAPABLE_MASK[gi];
				assign sclk_init = sclk_other;
			end

			assign pif.init_mode = init_local ? MODE_LOCAL : MODE_GLOBAL; // RULE14
			// Each port sees only its own request, so others are never touched
			assign pif.change_req = mode_wr_i &&
				(mode_wr_port_i == PORT_IDX_W'(gi)); // RULE15
			// A port without its own clock input stays global
			assign pif.change_mode = mode_wr_value_i && (gi == 0 || LOCAL_CAPABLE_MASK[gi]);
			assign pif.port_disabled = port_disabled_i[gi];

			prcm_port_ctl u_ctl (
				.mclk_i(mclk_i),
				.reset_i(reset_i),
				.pif(pif)
			);

			assign mode_bus[gi] = pif.port_clock_mode_field;
			assign busy_bus[gi] = pif.busy;
			// Global mode selects the global reference, local mode the port reference
			assign ref_sel_local_o[gi] = (pif.port_clock_mode_field == MODE_LOCAL); // RULE1 RULE2
			assign phy_force_detect_o[gi] = pif.force_detect;
			assign serdes_reinit_o[gi] = pif.serdes_reinit;
			assign link_retrain_o[gi] = pif.retrain;

			assign sclk_bus[gi] = sclk_init;
		end
	endgenerate

	// ****************************************
	// Status outputs
	// ****************************************
	// Slot clock bits are loaded only while reset is held
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			slot_clock_cfg_o <= sclk_bus; // RULE14
		end
	end

	assign port_clock_mode_reg_o = mode_bus; // RULE13
	assign mode_change_busy_o = busy_bus;
	// Link loss caused by a mode change is not a surprise
	assign surprise_link_down_o = phy_link_down_i & ~busy_bus; // RULE5

endmodule

// ===== rtl/prcm_pkg.sv
// Package: constants and types for the port reference clock mode select block
package prcm_pkg;

	// ****************************************
	// Structure
	// ****************************************
	localparam int NUM_PORTS = 16;
	localparam int PORT_IDX_W = 4;
	// Ports other than 0 that can run from their own reference clock (bit per port)
	localparam logic [15:0] LOCAL_CAPABLE_MASK = 16'hfffe;

	// ****************************************
	// Mode field encoding
	// ****************************************
	localparam logic MODE_GLOBAL = 1'b0;
	localparam logic MODE_LOCAL = 1'b1;

	// ****************************************
	// Boot strap encodings
	// ****************************************
	localparam logic [2:0] STRAP_RESERVED = 3'h7;
	localparam logic [2:0] STRAP_ALL_LOCAL = 3'h4;
	localparam logic [2:0] STRAP_LOCAL_NOT0_A = 3'h5;
	localparam logic [2:0] STRAP_LOCAL_NOT0_B = 3'h6;
	// Slot clock bit per strap value, indexed by the strap value
	localparam logic [7:0] SCLK_PORT0_TABLE = 8'h5a;
	localparam logic [7:0] SCLK_OTHER_TABLE = 8'h7c;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 4000;
	localparam int DETECT_HOLD_NS = 40;
	localparam int SERDES_REINIT_NS = 200;
	localparam int DETECT_HOLD_CYCLES =
		(DETECT_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SERDES_REINIT_CYCLES =
		(SERDES_REINIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 8;

	// ****************************************
	// Per-port sequencer states
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DETECT = 2'b01,
		ST_REINIT = 2'b10,
		ST_TRAIN = 2'b11
	} prcm_state_type;

endpackage

// ===== rtl/prcm_port_if.sv
// Interface: signals between the top level and one per-port sequencer
`timescale 1ns/100ps
interface prcm_port_if;
	logic init_mode;
	logic change_req;
	logic change_mode;
	logic port_disabled;
	logic port_clock_mode_field;
	logic force_detect;
	logic serdes_reinit;
	logic retrain;
	logic busy;

	modport ctl (
		input init_mode,
		input change_req,
		input change_mode,
		input port_disabled,
		output port_clock_mode_field,
		output force_detect,
		output serdes_reinit,
		output retrain,
		output busy
	);

	modport top (
		output init_mode,
		output change_req,
		output change_mode,
		output port_disabled,
		input port_clock_mode_field,
		input force_detect,
		input serdes_reinit,
		input retrain,
		input busy
	);
endinterface

// ===== rtl/prcm_port_ctl.sv
// Per-port clock mode holder and mode change sequencer
`timescale 1ns/100ps
module prcm_port_ctl
	import prcm_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// Top level side
	prcm_port_if.ctl pif
);

	// ****************************************
	// State
	// ****************************************
	prcm_state_type state;
	prcm_state_type next_state;
	logic mode;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic ref_changes;
	logic count_done;

	// A request only counts when it moves the port to the other reference clock
	assign ref_changes = pif.change_req && (pif.change_mode != mode);
	assign count_done = (count == '0);

	assign pif.port_clock_mode_field = mode;
	assign pif.force_detect = (state == ST_DETECT) || (state == ST_REINIT); // RULE5
	assign pif.serdes_reinit = (state == ST_REINIT); // RULE6
	assign pif.retrain = (state == ST_TRAIN) && !pif.port_disabled; // RULE7
	assign pif.busy = (state != ST_IDLE);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_state = state;
		next_count = count;
		if (count != '0) begin
			next_count = count - 1'b1;
		end
		case (state)
			ST_IDLE: begin
			end
			ST_DETECT: begin
				if (count_done) begin
					next_state = ST_REINIT;
					next_count = CNT_W'(SERDES_REINIT_CYCLES - 1);
				end
			end
			ST_REINIT: begin
				if (count_done) begin
					next_state = ST_TRAIN;
				end
			end
			ST_TRAIN: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// A change is accepted at any time and restarts the sequence
		if (ref_changes) begin // RULE4
			next_state = ST_DETECT; // RULE5
			next_count = CNT_W'(DETECT_HOLD_CYCLES - 1);
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state <= ST_IDLE;
			count <= '0;
			mode <= pif.init_mode; // RULE14
		end else begin
			state <= next_state;
			count <= next_count;
			if (ref_changes) begin
				mode <= pif.change_mode; // RULE13
			end
		end
	end

endmodule

// ===== verif/prcm_chk.sv
// Checker: port-level assertions for the reference clock mode select block
`timescale 1ns/100ps
module prcm_chk
	import prcm_pkg::*;
(
	// Watched top level ports
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [2:0] boot_clock_mode_straps_i,
	input wire logic mode_wr_i,
	input wire logic [PORT_IDX_W-1:0] mode_wr_port_i,
	input wire logic mode_wr_value_i,
	input wire logic [NUM_PORTS-1:0] port_disabled_i,
	input wire logic [NUM_PORTS-1:0] port_clock_mode_reg_o,
	input wire logic [NUM_PORTS-1:0] ref_sel_local_o,
	input wire logic [NUM_PORTS-1:0] phy_force_detect_o,
	input wire logic [NUM_PORTS-1:0] serdes_reinit_o,
	input wire logic [NUM_PORTS-1:0] link_retrain_o,
	input wire logic [NUM_PORTS-1:0] surprise_link_down_o,
	input wire logic [NUM_PORTS-1:0] mode_change_busy_o,
	input wire logic [2:0] boot_clock_mode_o
);
	// ****
	// Assertions
	// ****
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	sequence s_wr3;
		mode_wr_i && mode_wr_port_i == 4'h3 && mode_wr_value_i != port_clock_mode_reg_o[3];
	endsequence
	sequence s_hold3;
		phy_force_detect_o[3] [*8];
	endsequence
	ref_follow_a: assert property (ref_sel_local_o == port_clock_mode_reg_o)
		else $error("reference select differs from mode field");
	change_detect_a: assert property (
		((port_clock_mode_reg_o ^ $past(port_clock_mode_reg_o)) & ~phy_force_detect_o) == 0)
		else $error("mode changed without detect");
	walk_three_a: assert property (s_wr3 |=> s_hold3 ##3 serdes_reinit_o[3]
		##50 (link_retrain_o[3] || port_disabled_i[3]))
		else $error("mode change sequence wrong on port 3");
	retrain_cause_a: assert property ((link_retrain_o & ~$past(serdes_reinit_o)) == 0)
		else $error("retrain without prior reinit");
	retrain_off_a: assert property ((link_retrain_o & port_disabled_i) == 0)
		else $error("retrain on disabled port");
	quiet_link_a: assert property ((surprise_link_down_o & (phy_force_detect_o
		| $past(phy_force_detect_o))) == 0)
		else $error("surprise link down during mode change");
	reinit_inside_a: assert property ((serdes_reinit_o & ~phy_force_detect_o) == 0)
		else $error("reinit outside detect hold");
	others_keep_a: assert property (mode_wr_i |=> ((port_clock_mode_reg_o
		^ $past(port_clock_mode_reg_o)) & ~(16'h1 << $past(mode_wr_port_i))) == 0)
		else $error("write disturbed another port");
	boot_cap_a: assert property (disable iff (1'b0) reset_i
		&& boot_clock_mode_straps_i != 3'h7 |=> boot_clock_mode_o == $past(boot_clock_mode_straps_i))
		else $error("strap not captured");
endmodule
bind prcm_top prcm_chk chk_u (.mclk_i, .reset_i, .boot_clock_mode_straps_i, .mode_wr_i,
	.mode_wr_port_i, .mode_wr_value_i, .port_disabled_i, .port_clock_mode_reg_o,
	.ref_sel_local_o, .phy_force_detect_o, .serdes_reinit_o, .link_retrain_o,
	.surprise_link_down_o, .mode_change_busy_o, .boot_clock_mode_o);

// ===== verif/prcm_link_partner.sv
// Partner: serial link partner as seen through the port PHYs
`timescale 1ns/100ps
module prcm_link_partner #(
	parameter int GLOBAL_MHZ = 100,
	parameter int PORT_MHZ = 100,
	parameter bit GLOBAL_SSC = 1'b0,
	parameter logic [15:0] PORT_SSC = 16'h0000,
	parameter logic [15:0] SHARED_REF = 16'hffff
) (
	// Clock
	input wire logic mclk_i,
	// Reference selection, PHY detect hold and injected cable cuts
	input wire logic [15:0] ref_sel_local_i,
	input wire logic [15:0] force_detect_i,
	input wire logic [15:0] cut_i,
	// Link state back to the device
	output logic [15:0] link_down_o
);
	// ****
	// Link state
	// ****
	logic [15:0] bad_cfg;
	// A local clocked port cannot hold lock on a mismatched or illegally spread reference
	assign bad_cfg = ref_sel_local_i & ({16{GLOBAL_SSC}}
		| (PORT_SSC & ~SHARED_REF)
		| {16{PORT_MHZ != GLOBAL_MHZ}});
	// The link is lost while the PHY sits in detect, or when a cut is injected
	always_ff @(posedge mclk_i) begin
		link_down_o <= force_detect_i | cut_i | bad_cfg;
	end
endmodule

// ===== verif/tb_top.sv
// Testbench: boot straps, mode change sequencing and port isolation
`timescale 1ns/100ps
module tb_top;
	// ****
	// Bench
	// ****
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [2:0] straps = 3'h0;
	logic fsel = 1'b0;
	logic wr = 1'b0;
	logic [3:0] wr_port = 4'h0;
	logic wr_val = 1'b0;
	logic [15:0] dis = 16'h0000;
	logic [15:0] cut = 16'h0000;
	logic [15:0] link_down, mode, ref_sel, sclk, det, reinit, retrain, surprise, busy;
	logic [2:0] boot_o;
	logic fsel_o;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;
	// Strap level taken here as the 100 MHz global clock choice
	localparam logic FSEL_100 = 1'b0;
	always #2 mclk_i = ~mclk_i;
	prcm_top dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .boot_clock_mode_straps_i(straps),
		.global_clock_freq_select_i(fsel), .mode_wr_i(wr), .mode_wr_port_i(wr_port),
		.mode_wr_value_i(wr_val), .port_disabled_i(dis), .phy_link_down_i(link_down),
		.port_clock_mode_reg_o(mode), .ref_sel_local_o(ref_sel), .slot_clock_cfg_o(sclk),
		.phy_force_detect_o(det), .serdes_reinit_o(reinit), .link_retrain_o(retrain),
		.surprise_link_down_o(surprise), .mode_change_busy_o(busy),
		.boot_clock_mode_o(boot_o), .global_clock_freq_select_o(fsel_o));
	prcm_link_partner #(.PORT_SSC(16'h0008), .SHARED_REF(16'h0008)) pm_u (.mclk_i(mclk_i),
		.ref_sel_local_i(ref_sel), .force_detect_i(det), .cut_i(cut),
		.link_down_o(link_down));
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic do_reset(input logic [2:0] s);
		reset_i = 1'b1;
		straps = s;
		fsel = s[0];
		repeat (12) @(negedge mclk_i);
		reset_i = 1'b0;
		@(negedge mclk_i);
	endtask
	// One-cycle write; returns with the second answer cycle settled
	task automatic wr1(input logic [3:0] p, input logic v);
		wr = 1'b1;
		wr_port = p;
		wr_val = v;
		@(negedge mclk_i);
		wr = 1'b0;
		@(negedge mclk_i);
	endtask
	task automatic t_boot;
		logic [2:0] s;
		logic [15:0] m;
		logic [15:0] c;
		for (int i = 0; i < 8; i++) begin
			s = i[2:0];
			do_reset(s);
			m = (s == 3'h4) ? 16'hffff : (s == 3'h5 || s == 3'h6) ? 16'hfffe : 16'h0000;
			c = {{15{s >= 3'h2 && s <= 3'h6}}, s == 3'h1 || s == 3'h3 || s == 3'h4 || s == 3'h6};
			chk("mode", m, mode);
			chk("ref_sel", m, ref_sel);
			chk("sclk", c, sclk);
			chk("boot", {13'h0, (s == 3'h7) ? 3'h0 : s}, {13'h0, boot_o});
			chk("fsel", {15'h0, s[0]}, {15'h0, fsel_o});
		end
		$display("test boot done");
	endtask
	task automatic t_walk;
		do_reset(3'h0);
		wr1(4'h3, 1'b1);
		chk("mode", 16'h0008, mode);
		chk("ref_sel", 16'h0008, ref_sel);
		chk("detect", 16'h0008, det);
		repeat (10) @(negedge mclk_i);
		chk("reinit", 16'h0008, reinit);
		chk("surprise", 16'h0000, surprise);
		repeat (49) @(negedge mclk_i);
		chk("retrain", 16'h0008, retrain);
		chk("detect", 16'h0000, det);
		@(negedge mclk_i);
		chk("busy", 16'h0000, busy);
		cut = 16'h0008;
		@(negedge mclk_i);
		chk("surprise", 16'h0008, surprise);
		cut = 16'h0000;
		$display("test walk done");
	endtask
	task automatic t_disabled;
		dis = 16'h0020;
		wr1(4'h5, 1'b1);
		repeat (59) @(negedge mclk_i);
		chk("busy", 16'h0020, busy);
		chk("retrain", 16'h0000, retrain);
		chk("mode", 16'h0028, mode);
		@(negedge mclk_i);
		chk("busy", 16'h0000, busy);
		dis = 16'h0000;
		$display("test disabled done");
	endtask
	task automatic t_back;
		chk("fsel", {15'h0, FSEL_100}, {15'h0, fsel_o});
		wr1(4'h3, 1'b0);
		chk("ref_sel", 16'h0020, ref_sel);
		chk("detect", 16'h0008, det);
		repeat (59) @(negedge mclk_i);
		chk("retrain", 16'h0008, retrain);
		@(negedge mclk_i);
		chk("busy", 16'h0000, busy);
		$display("test back done");
	endtask
	// A write of the mode a port already has starts nothing
	task automatic t_same;
		wr1(4'h3, 1'b0);
		chk("busy", 16'h0000, busy);
		chk("detect", 16'h0000, det);
		$display("test same done");
	endtask
	// A second change in mid-sequence restarts the detect hold
	task automatic t_restart;
		wr1(4'h7, 1'b1);
		repeat (4) @(negedge mclk_i);
		wr1(4'h7, 1'b0);
		repeat (4) @(negedge mclk_i);
		chk("reinit", 16'h0000, reinit);
		chk("detect", 16'h0080, det);
		chk("mode", 16'h0020, mode);
		repeat (55) @(negedge mclk_i);
		chk("retrain", 16'h0080, retrain);
		@(negedge mclk_i);
		chk("busy", 16'h0000, busy);
		$display("test restart done");
	endtask
	initial begin
		t_boot();
		t_walk();
		t_disabled();
		t_back();
		t_same();
		t_restart();
		conclude();
	end
	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			n_mismatch++;
			conclude();
		end
	end
endmodule
